/* rtl/wwdru_top.sv */
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "wwdru_defs.svh"
// Supervisor timer with keyed refresh, write-once setup and unlock.
module wwdru_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic lpo_clk_in,
  input wire logic irc_clk_in,
  input wire logic ext_clk_in,
  input wire logic dbg_halt,
  input wire logic wait_mode,
  input wire logic deep_sleep_mode,
  output logic wdt_irq,
  output logic sys_reset_req
);
  import wwdru_pkg::*;
  // ****************************************************
  // State.
  // ****************************************************
  // All state of the top level in one record; the tick and backup submodules keep their own.
  typedef struct packed {
    logic [7:0] cs1; // Active control one.
    logic [7:0] cs2; // Active control two, flag bit unused.
    logic [15:0] tov; // Active timeout value.
    logic [15:0] early_refresh_guard; // Active window value.
    logic [7:0] p_cs1; // Pending copies written by software.
    logic [7:0] p_cs2;
    logic [15:0] p_tov;
    logic [15:0] p_win;
    logic [5:0] mask; // Pending field already written.
    logic cfg_open; // Configuration period running.
    logic [7:0] cfg_cnt; // Bus clocks into that period.
    logic unl; // Period was opened by an unlock.
    logic [7:0] hi; // Latched high byte of a count write.
    wwdru_seq_e seq; // Key sequence progress.
    logic [4:0] gap; // Bus clocks since the first word.
    logic [15:0] cnt; // The counter.
    wwdru_hold_e hold; // Zero hold phase.
    logic [2:0] hold_cnt; // Half periods in the phase.
    wwdru_src_t old_src; // Source before the change.
    logic flag; // Interrupt flag.
    logic pend; // Reset is being delayed.
    logic [7:0] dly; // Bus clocks of delay so far.
    logic irq; // Registered interrupt line.
    logic rst; // Registered reset request.
    logic [7:0] rdata; // Registered read data.
  } wwdru_top_s;
  wwdru_top_s st_r;
  wwdru_top_s st_nxt;
  // ****************************************************
  // Helpers.
  // ****************************************************
  // Mode gating: halt and deep sleep also need a non-bus source.
  function automatic logic run_ok(input logic [7:0] c1,
                                  input wwdru_src_t src,
                                  input logic dbg, input logic wt,
                                  input logic dp);
    logic nb;
    nb = (src != 2'h0);
    run_ok = !(dbg && !(c1[`WWDRU_C1_KEEP_DBG] && nb)) &&
             !(wt && !c1[`WWDRU_C1_KEEP_WAIT]) &&
             !(dp && !(c1[`WWDRU_C1_KEEP_DEEP] && nb));
  endfunction
  logic lo_wr; // Low byte of the count pair written.
  logic [15:0] word; // Full word of that write.
  logic evt; // Reset-triggering event this cycle.
  logic refresh; // Completed refresh this cycle.
  logic ovf; // Counter reached the timeout value.
  logic run; // Counter may advance.
  logic complete; // Pending configuration written, the window pair only when the guard is on.
  logic tick; // Prescaled tick of the selected source.
  logic half; // Undivided half period of that source.
  logic bkp_rst; // Backup logic demands a reset.
  wwdru_src_t cur_src;
  wwdru_src_t tick_sel;
  assign lo_wr = reg_wr && (reg_addr == `WWDRU_OFS_CNT_LO);
  assign word = {st_r.hi, reg_wdata};
  assign cur_src = st_r.cs2[1:0];
  // During the first hold phase the old source keeps ticking.
  assign tick_sel = (st_r.hold == HOLD_OLD) ? st_r.old_src : cur_src;
  assign run = run_ok(st_r.cs1, cur_src, dbg_halt, wait_mode,
                      deep_sleep_mode);
  // The window pair only counts when the guard is on.
  assign complete = (&st_r.mask[3:0]) && ((&st_r.mask[5:4]) ||
                    !st_r.p_cs2[`WWDRU_C2_GUARD]);
  // ****************************************************
  // Submodules.
  // ****************************************************
  // Tick source selection and prescaler.
  wwdru_tick_gen #(.DIV_W(8)) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .lpo_clk_in(lpo_clk_in),
    .irc_clk_in(irc_clk_in),
    .ext_clk_in(ext_clk_in),
    .tick_sel(tick_sel),
    .div_en(st_r.cs2[`WWDRU_C2_DIV]),
    .tick(tick),
    .half(half)
  );
  // Backup overflow watcher, only armed off the bus clock.
  wwdru_backup u_bkp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bkp_en(cur_src != 2'h0),
    .ovf(ovf),
    .clr(refresh),
    .bkp_rst(bkp_rst)
  );
  // ****************************************************
  // Next state.
  // ****************************************************
  // The top-level behaviour is worked out here from the current state; ticks and the backup reset come from submodules.
  always_comb begin
    st_nxt = st_r;
    evt = 1'b0;
    refresh = 1'b0;
    ovf = 1'b0;
    st_nxt.rdata = 8'h00;
    // Read data stands for one cycle only.
    if (reg_rd) begin
      case (reg_addr)
        `WWDRU_OFS_CTL1: st_nxt.rdata = st_r.cs1;
        `WWDRU_OFS_CTL2: begin
          st_nxt.rdata = st_r.cs2;
          st_nxt.rdata[`WWDRU_C2_FLAG] = st_r.flag;
        end
        `WWDRU_OFS_CNT_HI: st_nxt.rdata = st_r.cnt[15:8];
        `WWDRU_OFS_CNT_LO: st_nxt.rdata = st_r.cnt[7:0];
        `WWDRU_OFS_TOV_HI: st_nxt.rdata = st_r.tov[15:8];
        `WWDRU_OFS_TOV_LO: st_nxt.rdata = st_r.tov[7:0];
        `WWDRU_OFS_WIN_HI: st_nxt.rdata = st_r.early_refresh_guard[15:8];
        `WWDRU_OFS_WIN_LO: st_nxt.rdata = st_r.early_refresh_guard[7:0];
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // The high byte waits until the low byte completes the word.
    if (reg_wr && (reg_addr == `WWDRU_OFS_CNT_HI)) begin
      st_nxt.hi = reg_wdata;
    end
    if (st_r.seq != SEQ_IDLE) begin
      st_nxt.gap = st_r.gap + 5'h01;
    end
    // Key sequences on the count pair.
    if (lo_wr) begin
      st_nxt.seq = SEQ_IDLE;
      case (st_r.seq)
        SEQ_IDLE: begin
          if (word == `WWDRU_KEY_REF1) begin
            if (st_r.cs2[`WWDRU_C2_GUARD] && (st_r.cnt < st_r.early_refresh_guard)) begin
              evt = 1'b1;
            end else begin
              st_nxt.seq = SEQ_REF1;
              st_nxt.gap = 5'h01;
            end
          end else if ((word == `WWDRU_KEY_UNL1) && !st_r.cfg_open &&
                       st_r.cs1[`WWDRU_C1_PERMIT]) begin
            st_nxt.seq = SEQ_UNL1;
            st_nxt.gap = 5'h01;
          end else begin
            evt = 1'b1;
          end
        end
        SEQ_REF1: begin
          if (word == `WWDRU_KEY_REF2) begin
            refresh = 1'b1;
          end else begin
            evt = 1'b1;
          end
        end
        SEQ_UNL1: begin
          if (word == `WWDRU_KEY_UNL2) begin
            // Reopen the setup period with the active values pending.
            st_nxt.cfg_open = 1'b1;
            st_nxt.cfg_cnt = 8'h00;
            st_nxt.unl = 1'b1;
            st_nxt.mask = 6'h00;
            st_nxt.p_cs1 = st_r.cs1;
            st_nxt.p_cs2 = st_r.cs2;
            st_nxt.p_tov = st_r.tov;
            st_nxt.p_win = st_r.early_refresh_guard;
          end else begin
            evt = 1'b1;
          end
        end
        default: evt = 1'b1;
      endcase
    end else if ((st_r.seq != SEQ_IDLE) && (st_r.gap == `WWDRU_GAP_CYC)) begin
      // The second word did not come in time.
      st_nxt.seq = SEQ_IDLE;
      evt = 1'b1;
    end
    // Write-once pending fields while the setup period runs.
    if (reg_wr && st_r.cfg_open) begin
      case (reg_addr)
        `WWDRU_OFS_CTL1: if (!st_r.mask[0]) begin
          st_nxt.p_cs1 = reg_wdata & `WWDRU_C1_MASK;
          st_nxt.mask[0] = 1'b1;
        end
        `WWDRU_OFS_CTL2: if (!st_r.mask[1]) begin
          st_nxt.p_cs2 = reg_wdata & `WWDRU_C2_MASK & 8'hbf;
          st_nxt.mask[1] = 1'b1;
        end
        `WWDRU_OFS_TOV_HI: if (!st_r.mask[2]) begin
          st_nxt.p_tov[15:8] = reg_wdata;
          st_nxt.mask[2] = 1'b1;
        end
        `WWDRU_OFS_TOV_LO: if (!st_r.mask[3]) begin
          st_nxt.p_tov[7:0] = reg_wdata;
          st_nxt.mask[3] = 1'b1;
        end
        `WWDRU_OFS_WIN_HI: if (!st_r.mask[4]) begin
          st_nxt.p_win[15:8] = reg_wdata;
          st_nxt.mask[4] = 1'b1;
        end
        `WWDRU_OFS_WIN_LO: if (!st_r.mask[5]) begin
          st_nxt.p_win[7:0] = reg_wdata;
          st_nxt.mask[5] = 1'b1;
        end
        default: st_nxt.mask = st_nxt.mask;
      endcase
    end
    // Writing one to the flag clears it; a new event still sets it.
    if (reg_wr && (reg_addr == `WWDRU_OFS_CTL2) &&
        reg_wdata[`WWDRU_C2_FLAG]) begin
      st_nxt.flag = 1'b0;
    end
    // Setup period: apply at its end only if the control and timeout fields, and the window pair when the guard is on, were written.
    if (st_r.cfg_open) begin
      st_nxt.cfg_cnt = st_r.cfg_cnt + 8'h01;
      if (st_r.cfg_cnt == (`WWDRU_CFG_CYC - 8'h01)) begin
        st_nxt.cfg_open = 1'b0;
        st_nxt.unl = 1'b0;
        if (complete) begin
          st_nxt.cs1 = st_r.p_cs1;
          st_nxt.cs2 = st_r.p_cs2;
          st_nxt.tov = st_r.p_tov;
          st_nxt.early_refresh_guard = st_r.p_win;
          if (st_r.p_cs2[1:0] != cur_src) begin
            st_nxt.hold = HOLD_OLD;
            st_nxt.hold_cnt = 3'h0;
            st_nxt.old_src = cur_src;
            st_nxt.cnt = 16'h0000;
          end
        end else if (st_r.unl) begin
          st_nxt.rst = 1'b1;
        end
      end
    end
    // Counter: zero hold, refresh, timeout compare, or advance.
    if (st_r.hold != HOLD_NONE) begin
      st_nxt.cnt = 16'h0000;
      if (half) begin
        st_nxt.hold_cnt = st_r.hold_cnt + 3'h1;
        if (st_r.hold_cnt == (`WWDRU_HOLD_HALF - 3'h1)) begin
          st_nxt.hold_cnt = 3'h0;
          st_nxt.hold = (st_r.hold == HOLD_OLD) ? HOLD_NEW : HOLD_NONE;
        end
      end
    end else if (refresh) begin
      st_nxt.cnt = 16'h0000;
    end else if (run && (st_r.cnt >= st_r.tov)) begin
      // Compared every running cycle; clearing to zero lets a second overflow show.
      ovf = 1'b1;
      evt = 1'b1;
      st_nxt.cnt = 16'h0000;
    end else if (run && tick) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    // A reset-triggering event: interrupt first, or reset now.
    if (evt && !st_r.pend && !st_r.rst) begin
      if (st_r.cs1[`WWDRU_C1_IRQ_FIRST]) begin
        st_nxt.pend = 1'b1;
        st_nxt.dly = 8'h00;
        st_nxt.flag = 1'b1;
      end else begin
        st_nxt.rst = 1'b1;
      end
    end
    if (st_r.pend) begin
      st_nxt.dly = st_r.dly + 8'h01;
      if (st_r.dly == (`WWDRU_IRQ_DLY - 8'h01)) begin
        st_nxt.rst = 1'b1;
      end
    end
    if (bkp_rst) begin
      st_nxt.rst = 1'b1;
    end
    // The interrupt line stays quiet in deep sleep.
    st_nxt.irq = st_nxt.flag && st_r.cs1[`WWDRU_C1_IRQ_FIRST] &&
                 !deep_sleep_mode;
  end
  // ****************************************************
  // State register.
  // ****************************************************
  // Reset brings back the default setup and opens the setup period.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.cs1 <= `WWDRU_RST_CTL1;
      st_r.cs2 <= `WWDRU_RST_CTL2;
      st_r.tov <= `WWDRU_RST_TOV;
      st_r.early_refresh_guard <= `WWDRU_RST_WIN;
      st_r.p_cs1 <= `WWDRU_RST_CTL1;
      st_r.p_cs2 <= `WWDRU_RST_CTL2;
      st_r.p_tov <= `WWDRU_RST_TOV;
      st_r.p_win <= `WWDRU_RST_WIN;
      st_r.cfg_open <= 1'b1;
      st_r.seq <= SEQ_IDLE;
      st_r.hold <= HOLD_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign reg_rdata = st_r.rdata;
  assign wdt_irq = st_r.irq;
  assign sys_reset_req = st_r.rst;
  // ****************************************************
  // Checks.
  // ****************************************************
  AST_REFRESH_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (refresh && st_r.hold == HOLD_NONE) |=> st_r.cnt == 16'h0000)
    else $error("Refresh did not zero the counter.");
  AST_GAP_LATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r.seq == SEQ_REF1 && st_r.gap == 5'h10 && !lo_wr)
    |-> ##[1:130] sys_reset_req)
    else $error("Late second refresh word gave no reset.");
  AST_WRITE_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r.mask[0] && reg_wr && reg_addr == `WWDRU_OFS_CTL1)
    |=> $stable(st_r.p_cs1))
    else $error("Control one changed on a second write.");
  AST_IRQ_DELAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($rose(st_r.pend) && !sys_reset_req && !bkp_rst)
    |-> ##1 !sys_reset_req ##127 sys_reset_req)
    else $error("Delayed reset not at 128 bus clocks.");
  AST_NO_DELAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (evt && !st_r.cs1[`WWDRU_C1_IRQ_FIRST] && !st_r.pend)
    |=> sys_reset_req && !wdt_irq)
    else $error("Event without irq first did not reset at once.");
  AST_DEEP_NO_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    deep_sleep_mode |=> !wdt_irq)
    else $error("Interrupt raised in deep sleep.");
  AST_TIMEOUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ovf && !st_r.pend && !st_r.rst)
    |=> (st_r.cnt == 16'h0000) && (st_r.pend || sys_reset_req))
    else $error("Timeout match not acted on.");
  AST_CFG_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r.hold != HOLD_NONE) |-> st_r.cnt == 16'h0000)
    else $error("Counter moved during the zero hold.");
  AST_UNLOCK_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r.cfg_open && st_r.unl && st_r.cfg_cnt == 8'h7f && !complete)
    |=> sys_reset_req)
    else $error("Unconfigured unlock did not reset.");
endmodule

/* common/wwdru_defs.svh */
`ifndef WWDRU_DEFS_SVH
`define WWDRU_DEFS_SVH
// ****************************************************
// Register byte offsets.
// ****************************************************
`define WWDRU_OFS_CTL1 3'h0
`define WWDRU_OFS_CTL2 3'h1
`define WWDRU_OFS_CNT_HI 3'h2
`define WWDRU_OFS_CNT_LO 3'h3
`define WWDRU_OFS_TOV_HI 3'h4
`define WWDRU_OFS_TOV_LO 3'h5
`define WWDRU_OFS_WIN_HI 3'h6
`define WWDRU_OFS_WIN_LO 3'h7
// ****************************************************
// Field positions and writable masks.
// ****************************************************
`define WWDRU_C1_IRQ_FIRST 5
`define WWDRU_C1_PERMIT 4
`define WWDRU_C1_KEEP_DBG 2
`define WWDRU_C1_KEEP_WAIT 1
`define WWDRU_C1_KEEP_DEEP 0
`define WWDRU_C1_MASK 8'h37
`define WWDRU_C2_GUARD 7
`define WWDRU_C2_FLAG 6
`define WWDRU_C2_DIV 4
`define WWDRU_C2_MASK 8'h93
// ****************************************************
// Reset values and key words.
// ****************************************************
`define WWDRU_RST_CTL1 8'h00
`define WWDRU_RST_CTL2 8'h01
`define WWDRU_RST_TOV 16'h0004
`define WWDRU_RST_WIN 16'h0000
`define WWDRU_KEY_REF1 16'ha602
`define WWDRU_KEY_REF2 16'hb480
`define WWDRU_KEY_UNL1 16'hc520
`define WWDRU_KEY_UNL2 16'hd928
// ****************************************************
// Timing counts in bus clocks or half periods.
// ****************************************************
`define WWDRU_GAP_CYC 5'h10
`define WWDRU_CFG_CYC 8'h80
`define WWDRU_IRQ_DLY 8'h80
`define WWDRU_HOLD_HALF 3'h5
`endif

/* common/wwdru_pkg.sv */
// ****************************************************
// Shared types of the supervisor timer.
// ****************************************************
package wwdru_pkg;
  // Tick source code; 0 is the bus clock.
  typedef logic [1:0] wwdru_src_t;
  // Progress through a two-word key sequence.
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_REF1, SEQ_UNL1} wwdru_seq_e;
  // Phases of the zero hold after a source change.
  typedef enum logic [1:0] {HOLD_NONE, HOLD_OLD, HOLD_NEW} wwdru_hold_e;
endpackage

/* rtl/wwdru_tick_gen.sv */
`timescale 1ns/10ps
// Selects a tick source, detects its edges and prescales it.
module wwdru_tick_gen #(
  parameter int DIV_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic lpo_clk_in,
  input wire logic irc_clk_in,
  input wire logic ext_clk_in,
  input wire wwdru_pkg::wwdru_src_t tick_sel,
  input wire logic div_en,
  output logic tick,
  output logic half
);
  import wwdru_pkg::*;
  // Last source levels and the prescaler count.
  typedef struct packed {
    logic [2:0] lvl;
    logic [DIV_W-1:0] pre;
  } wwdru_tick_s;
  wwdru_tick_s st_r;
  wwdru_tick_s st_nxt;
  logic [2:0] lvl;
  logic raw;
  // Rising edge gives a full period, any edge a half period.
  always_comb begin
    lvl = {ext_clk_in, irc_clk_in, lpo_clk_in};
    st_nxt = st_r;
    st_nxt.lvl = lvl;
    raw = 1'b1;
    half = 1'b1;
    if (tick_sel != 2'h0) begin
      raw = lvl[tick_sel - 2'h1] & ~st_r.lvl[tick_sel - 2'h1];
      half = lvl[tick_sel - 2'h1] ^ st_r.lvl[tick_sel - 2'h1];
    end
    if (raw) begin
      st_nxt.pre = st_r.pre + {{(DIV_W-1){1'b0}}, 1'b1};
    end
    // Only the last edge of each 256 passes when dividing.
    tick = div_en ? (raw & (&st_r.pre)) : raw;
  end
  // State register.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* rtl/wwdru_backup.sv */
`timescale 1ns/10ps
// Independent overflow watcher; it keeps no link to the main state.
module wwdru_backup (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bkp_en,
  input wire logic ovf,
  input wire logic clr,
  output logic bkp_rst
);
  import wwdru_pkg::*;
  // One overflow seen, and the fire bit.
  typedef struct packed {
    logic seen;
    logic fire;
  } wwdru_bkp_s;
  wwdru_bkp_s st_r;
  wwdru_bkp_s st_nxt;
  // A refresh forgets the first overflow; a second one fires.
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.seen = 1'b0;
    end
    if (bkp_en && ovf) begin
      st_nxt.seen = 1'b1;
      st_nxt.fire = st_r.fire | st_r.seen;
    end
    bkp_rst = st_r.fire;
  end
  // State register.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import wwdru_pkg::*;
  // *****
  // Stimulus, observation and bookkeeping.
  // *****
  logic ref_clk = 1'b0; // Bus clock, 10 ns period.
  logic rst_n = 1'b0; // Synchronous reset, active low.
  logic [2:0] reg_addr = 3'h0; // Register offset.
  logic [7:0] reg_wdata = 8'h00; // Write data.
  logic reg_wr = 1'b0; // Write strobe.
  logic reg_rd = 1'b0; // Read strobe.
  logic [7:0] reg_rdata; // Read data.
  logic [7:0] div_cnt = 8'h00; // Divider for the slow tick sources.
  logic dbg_halt = 1'b0; // Debug halt level.
  logic wait_mode = 1'b0; // Wait mode level.
  logic deep_sleep_mode = 1'b0; // Deep sleep level.
  logic wdt_irq; // Interrupt output.
  logic sys_reset_req; // Reset request output.
  logic [7:0] rdv; // Last value read back.
  logic [31:0] seed = 32'h00017e9f; // Random state, starts at 97951.
  logic [15:0] w; // Random counter word.
  int n_fail = 0; // Mismatches seen.
  int samples_checked = 0; // Comparisons made.
  int k; // Cycle counter.
  // The slow sources toggle from a free divider; the oscillator stays
  // slow enough that the default 4-tick timeout cannot fire in setup.
  always @(posedge ref_clk) div_cnt <= div_cnt + 8'h01;
  // Clock generator.
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  wwdru_top u_wwdru_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lpo_clk_in(div_cnt[7]),
    .irc_clk_in(div_cnt[2]), .ext_clk_in(div_cnt[3]),
    .dbg_halt(dbg_halt), .wait_mode(wait_mode),
    .deep_sleep_mode(deep_sleep_mode),
    .wdt_irq(wdt_irq), .sys_reset_req(sys_reset_req));
  // *****
  // Tasks and functions.
  // *****
  // Galois-free shift register step; fixed taps keep runs repeatable.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Prints the verdict and ends the run.
  task report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Byte compare; four-state equality so an unknown matches only an unknown.
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One write cycle; an idle cycle follows so strobes never clash.
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One read cycle; data is taken in the single cycle it stands.
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // A counter word is the high byte then the low byte.
  task word(input logic [15:0] v);
    wr(3'h2, v[15:8]);
    wr(3'h3, v[7:0]);
  endtask
  // Setup writes timeout first, then the two control bytes.
  task cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [15:0] t);
    wr(3'h4, t[15:8]);
    wr(3'h5, t[7:0]);
    wr(3'h1, c2);
    wr(3'h0, c1);
  endtask
  // Reset for three cycles with every mode input back at idle.
  task rst3;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    dbg_halt <= 1'b0;
    wait_mode <= 1'b0;
    deep_sleep_mode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  // Reset, configure, then let the setup period close before any mode.
  task boot(input logic [7:0] c1, input logic [7:0] c2, input logic [15:0] t);
    rst3();
    cfg(c1, c2, t);
    repeat (130) @(posedge ref_clk);
  endtask
  // Watches the reset request for a bounded span and compares the outcome.
  task wait_rst(input int maxc, input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < maxc && !seen; i++) begin
      @(posedge ref_clk);
      #1;
      seen = (sys_reset_req === 1'b1);
    end
    chk({7'h00, seen}, {7'h00, exp});
  endtask
  // Cuts a hang short.
  initial begin
    #800us;
    n_fail++;
    report_and_stop();
  end
  // *****
  // Main sequence.
  // *****
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(3'h1, rdv);
    chk(rdv, 8'h01);
    rd(3'h5, rdv);
    chk(rdv, 8'h04);
    // Second write to a field after setup has closed must be ignored.
    boot(8'h10, 8'h00, 16'h0100);
    rd(3'h1, rdv);
    chk(rdv, 8'h00);
    wr(3'h1, 8'h03);
    rd(3'h1, rdv);
    chk(rdv, 8'h00);
    rd(3'h5, rdv);
    chk(rdv, 8'h00);
    word(16'ha602);
    word(16'hb480);
    rd(3'h3, rdv);
    chk({7'h00, rdv < 8'h08}, 8'h01);
    wait_rst(2000, 1'b1);
    chk({7'h00, wdt_irq}, 8'h00);
    // Same source with the prescaler keeps a tiny timeout far off.
    boot(8'h00, 8'h11, 16'h0002);
    wait_rst(1500, 1'b0);
    // Refresh within the gap, then unlock without permission.
    boot(8'h00, 8'h01, 16'hffff);
    seed = lfsr_next(seed);
    word(16'ha602);
    repeat (seed % 13) @(posedge ref_clk);
    word(16'hb480);
    wait_rst(200, 1'b0);
    word(16'hc520);
    word(16'hd928);
    wait_rst(10, 1'b1);
    // Second refresh word one cycle too late.
    boot(8'h00, 8'h01, 16'hffff);
    word(16'ha602);
    repeat (13) @(posedge ref_clk);
    word(16'hb480);
    wait_rst(10, 1'b1);
    // Random wrong word with interrupt first; count from the interrupt.
    boot(8'h20, 8'h01, 16'hffff);
    seed = lfsr_next(seed);
    w = (seed[15:0] == 16'ha602) ? 16'h1234 : seed[15:0];
    word(w);
    #1;
    for (k = 0; k < 5 && wdt_irq !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({7'h00, wdt_irq}, 8'h01);
    k = 0;
    while (sys_reset_req !== 1'b1 && k < 200) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk(k[7:0], 8'h80);
    // Unlock with permission, reconfigure, then unlock and abandon.
    boot(8'h10, 8'h01, 16'hffff);
    word(16'hc520);
    word(16'hd928);
    cfg(8'h10, 8'h11, 16'hffff);
    repeat (130) @(posedge ref_clk);
    rd(3'h1, rdv);
    chk(rdv, 8'h11);
    word(16'hc520);
    word(16'hd928);
    wait_rst(110, 1'b0);
    wait_rst(30, 1'b1);
    // Guarded refresh started before the window value; the window pair
    // must be written inside the setup period for the guard to apply.
    rst3();
    wr(3'h6, 8'hff);
    wr(3'h7, 8'h00);
    cfg(8'h00, 8'h81, 16'hffff);
    repeat (130) @(posedge ref_clk);
    rd(3'h1, rdv);
    chk(rdv, 8'h81);
    word(16'ha602);
    word(16'hb480);
    wait_rst(10, 1'b1);
    // Debug halt stops a bus-clocked counter even with keep-alive set.
    boot(8'h04, 8'h00, 16'h0100);
    dbg_halt <= 1'b1;
    wait_rst(1500, 1'b0);
    @(posedge ref_clk);
    dbg_halt <= 1'b0;
    wait_rst(1500, 1'b1);
    // Kept alive in wait and deep sleep: reset comes, interrupt stays low.
    boot(8'h23, 8'h01, 16'h0002);
    wait_mode <= 1'b1;
    deep_sleep_mode <= 1'b1;
    wait_rst(1500, 1'b1);
    chk({7'h00, wdt_irq}, 8'h00);
    rd(3'h1, rdv);
    chk(rdv, 8'h41);
    // Off the bus clock a second overflow in the delay resets early.
    boot(8'h20, 8'h03, 16'h0001);
    for (k = 0; k < 1500 && wdt_irq !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({7'h00, wdt_irq}, 8'h01);
    wait_rst(40, 1'b1);
    report_and_stop();
  end
endmodule
